// >>> rtl/ramp_limit_pkg.sv
`default_nettype none
package ramp_limit_pkg;
    // Register offsets (word addresses on the plain port)
    localparam logic [3:0] ADDR_PAIR_SELECT   = 4'h0;
    localparam logic [3:0] ADDR_UPPER_LIMIT   = 4'h1;
    localparam logic [3:0] ADDR_LOWER_LIMIT   = 4'h2;
    localparam logic [3:0] ADDR_DRIVE_CONFIG  = 4'h3;
    localparam logic [3:0] ADDR_COMPENSATION  = 4'h4;
    localparam logic [3:0] ADDR_ADJUST_SEL    = 4'h5;
    localparam logic [3:0] ADDR_ADJUST_VALUE  = 4'h6;
    localparam logic [3:0] ADDR_CONTROL       = 4'h7;
    localparam logic [3:0] ADDR_STATUS        = 4'h8;
    localparam logic [3:0] ADDR_SETPOINT      = 4'h9;
    localparam logic [3:0] ADDR_CHANNEL_GAIN  = 4'hA;
    localparam logic [3:0] ADDR_TERM_ASSIGN   = 4'hB;

    // Set-values are signed tenths of a percent
    localparam int         SETPOINT_W         = 16;
    localparam logic signed [15:0] LIMIT_MAX  = 16'sh0708; // +180.0 %
    localparam logic signed [15:0] LIMIT_MIN  = -16'sh0708; // -180.0 %
    localparam logic signed [15:0] FINE_SPAN  = 16'sh03E8; // 100.0 %
    localparam logic signed [15:0] COARSE_STEP = 16'sh000A; // 1 %
    localparam logic [15:0] COMP_MAX          = 16'h012C; // 30.0 %
    localparam logic [15:0] GAIN_UNITY        = 16'h03E8; // 100.0 %

    // Reset values
    localparam logic [3:0]  PAIR_SELECT_RST   = 4'h0;
    localparam logic signed [15:0] UPPER_RST  = 16'sh0708;
    localparam logic signed [15:0] LOWER_RST  = -16'sh0708;
    localparam logic [7:0]  DRIVE_CONFIG_RST  = 8'h0B;
    localparam logic [7:0]  ADJUST_SEL_RST    = 8'h00;

    // Drive configuration codes (decimal codes held as bytes)
    localparam logic [7:0]  CFG_SPEED_ARMV    = 8'h0A; // 10
    localparam logic [7:0]  CFG_SPEED_TACHO   = 8'h0B; // 11
    localparam logic [7:0]  CFG_TORQUE_ARMV   = 8'h28; // 40
    localparam logic [7:0]  CFG_TORQUE_TACHO  = 8'h29; // 41
    localparam logic [7:0]  ADJ_MAIN_CHANNEL  = 8'h04;

    // Control and status bit positions
    localparam int CTRL_TERMINAL_MODE_BIT     = 0;
    localparam int CTRL_INHIBIT_BIT           = 1;
    localparam int CTRL_FIELD_WEAKEN_BIT      = 2;
    localparam int CTRL_CONFIRM_BIT           = 3;
    localparam int STAT_ARMV_FB_BIT           = 0;
    localparam int STAT_TACHO_FB_BIT          = 1;
    localparam int STAT_FIELD_WEAKEN_BIT      = 2;
    localparam int STAT_GAIN_STORED_BIT       = 3;
    localparam int STAT_CLAMPED_BIT           = 4;
endpackage
`default_nettype wire

// >>> rtl/pair_select_sync.sv
`default_nettype none
module pair_select_sync #(
    parameter int INPUTS = 4
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic [INPUTS-1:0] pin_i,
    output logic [INPUTS-1:0]      level_o
);
    if (INPUTS < 1 || INPUTS > 8)
    begin : g_bad_inputs
        $error("pair_select_sync: INPUTS must be 1..8");
    end

    typedef struct packed {
        logic [INPUTS-1:0] s1;
        logic [INPUTS-1:0] s2;
        logic [INPUTS-1:0] s3;
        logic [INPUTS-1:0] level;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    // =========================================================
    // Three-stage sampling, change taken when stages 2 and 3 agree
    always_comb
    begin
        next_state    = state;
        next_state.s1 = pin_i;
        next_state.s2 = state.s1;
        next_state.s3 = state.s2;
        for (int i = 0; i < INPUTS; i++)
        begin
            if (state.s2[i] == state.s3[i])
                next_state.level[i] = state.s3[i];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            state <= '0;
        else
            state <= next_state;
    end

    assign level_o = state.level;
endmodule
`default_nettype wire

// >>> rtl/ramp_pair_limit.sv
// Contract
// - Accel and decel times switch only together as one pair index.
// - Terminal mode: four inputs form binary code, first input is LSB.
// - Assigned terminals ordered by number, lowest becomes least significant bit.
// - Pair select register always reads the pair in effect.
// - Keypad mode: operator writes 0 base pair, 1..15 extra pairs; default 0.
// - Terminal mode: writes to pair select are ignored.
// - Sum main and additional set-values, clamp between upper and lower limit.
// - Limits range -180..+180 %, 0.1 % fine steps, 1 % beyond 100 %.
// - Sum saturates at 180 % of the maximum speed reference.
// - Codes 10 and 40 select armature-voltage speed feedback.
// - Armature feedback applies load compensation, 0..30 % adjustable.
// - No field weakening while armature-voltage feedback is configured.
// - Codes 11 and 41 select DC tacho speed feedback.
// - Main channel gain stored only on confirm, inhibited, selector 4.
`default_nettype none
module ramp_pair_limit #(
    parameter int SEL_INPUTS = 4
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic [3:0]          addr_i,
    input  wire logic [15:0]         wdata_i,
    input  wire logic                wr_i,
    input  wire logic                rd_i,
    output logic [15:0]              rdata_o,
    input  wire logic [7:0]          terminal_i,
    input  wire logic                cycle_tick_i,
    input  wire logic signed [15:0]  main_setpoint_i,
    input  wire logic signed [15:0]  additional_setpoint_i,
    output logic [3:0]               active_pair_o,
    output logic                     use_base_times_o,
    output logic signed [15:0]       limited_speed_setpoint_o,
    output logic                     armature_feedback_o,
    output logic                     tacho_feedback_o,
    output logic [15:0]              load_drop_compensation_o,
    output logic                     field_weaken_enable_o,
    output logic [15:0]              main_channel_gain_o
);
    // =========================================================
    // Parameter checks
    if (SEL_INPUTS < 1 || SEL_INPUTS > 4)
    begin : g_bad_sel_inputs
        $error("ramp_pair_limit: SEL_INPUTS must be 1..4");
    end

    // Set-value arithmetic below is sized for 16-bit words
    if (ramp_limit_pkg::SETPOINT_W != 16)
    begin : g_bad_setpoint_width
        $error("ramp_pair_limit: SETPOINT_W must be 16");
    end

    // =========================================================
    // Register state
    typedef struct packed {
        logic [3:0]         pair;
        logic signed [15:0] upper;
        logic signed [15:0] lower;
        logic [7:0]         drive_configuration;
        logic [15:0]        compensation;
        logic [7:0]         adjust_sel;
        logic [15:0]        adjust_value;
        logic               terminal_mode;
        logic               inhibit;
        logic               field_weaken_req;
        logic [7:0]         term_assign;
        logic [15:0]        gain;
        logic               gain_stored;
        logic               clamped;
        logic signed [15:0] setpoint;
        logic [15:0]        rdata;
    } top_state_t;

    top_state_t state;
    top_state_t next_state;

    logic [7:0]  term_level;
    logic [3:0]  term_code;
    logic        armv;
    logic        tacho;
    logic signed [17:0] sum;
    logic signed [15:0] sat_sum;
    logic signed [15:0] floor_limit;
    logic [15:0]        read_word;

    // =========================================================
    // Terminal synchroniser
    // All eight pins pass it; the assignment mask picks the used ones
    pair_select_sync #(
        .INPUTS (8)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (terminal_i),
        .level_o (term_level)
    );

    // =========================================================
    // Terminal code: assigned inputs in ascending terminal order
    always_comb
    begin
        int bitpos;
        bitpos    = 0;
        term_code = 4'h0;
        for (int t = 0; t < 8; t++)
        begin
            if (state.term_assign[t] && bitpos < SEL_INPUTS)
            begin
                term_code[bitpos[1:0]] = term_level[t];
                bitpos = bitpos + 1;
            end
        end
    end

    // =========================================================
    // Feedback selection
    // Other codes use feedback paths outside this block
    always_comb
    begin
        armv  = 1'b0;
        tacho = 1'b0;
        case (state.drive_configuration)
            ramp_limit_pkg::CFG_SPEED_ARMV,
            ramp_limit_pkg::CFG_TORQUE_ARMV:   armv  = 1'b1;
            ramp_limit_pkg::CFG_SPEED_TACHO,
            ramp_limit_pkg::CFG_TORQUE_TACHO:  tacho = 1'b1;
            default:
            begin
            end
        endcase
    end

    // =========================================================
    // Arithmetic stage with saturation
    // Two spare bits keep the sum of two full-scale words exact
    assign sum = 18'(main_setpoint_i) + 18'(additional_setpoint_i);

    always_comb
    begin
        if (sum > 18'(ramp_limit_pkg::LIMIT_MAX))
            sat_sum = ramp_limit_pkg::LIMIT_MAX;
        else if (sum < 18'(ramp_limit_pkg::LIMIT_MIN))
            sat_sum = ramp_limit_pkg::LIMIT_MIN;
        else
            sat_sum = sum[15:0];
    end

    // =========================================================
    // Limits outside the range are pulled in; beyond 100 % the step is 1 %
    function automatic logic signed [15:0] legal_limit(input logic signed [15:0] v);
        logic signed [15:0] r;
        r = v;
        if (r > ramp_limit_pkg::LIMIT_MAX)
            r = ramp_limit_pkg::LIMIT_MAX;
        else if (r < ramp_limit_pkg::LIMIT_MIN)
            r = ramp_limit_pkg::LIMIT_MIN;
        if (r > ramp_limit_pkg::FINE_SPAN || r < -ramp_limit_pkg::FINE_SPAN)
            r = 16'((r / ramp_limit_pkg::COARSE_STEP) * ramp_limit_pkg::COARSE_STEP);
        return r;
    endfunction

    // Crossed limits are a configurer fault; the upper limit then wins
    assign floor_limit = (state.lower > state.upper) ? state.upper : state.lower;

    // =========================================================
    // Next state
    always_comb
    begin
        next_state = state;

        // Terminal pair changes only on a cycle boundary so the ramp sees one clean index
        if (state.terminal_mode && cycle_tick_i)
            next_state.pair = term_code;

        // Clamp stage
        if (sat_sum > state.upper)
        begin
            next_state.setpoint = state.upper;
            next_state.clamped  = 1'b1;
        end
        else if (sat_sum < floor_limit)
        begin
            next_state.setpoint = floor_limit;
            next_state.clamped  = 1'b1;
        end
        else
        begin
            next_state.setpoint = sat_sum;
            next_state.clamped  = 1'b0;
        end

        // Register writes
        if (wr_i)
        begin
            case (addr_i)
                ramp_limit_pkg::ADDR_PAIR_SELECT:
                begin
                    if (!state.terminal_mode)
                        next_state.pair = wdata_i[3:0];
                end
                ramp_limit_pkg::ADDR_UPPER_LIMIT:
                    next_state.upper = legal_limit(wdata_i);
                ramp_limit_pkg::ADDR_LOWER_LIMIT:
                    next_state.lower = legal_limit(wdata_i);
                ramp_limit_pkg::ADDR_DRIVE_CONFIG:
                    next_state.drive_configuration = wdata_i[7:0];
                ramp_limit_pkg::ADDR_COMPENSATION:
                begin
                    if (wdata_i > ramp_limit_pkg::COMP_MAX)
                        next_state.compensation = ramp_limit_pkg::COMP_MAX;
                    else
                        next_state.compensation = wdata_i;
                end
                ramp_limit_pkg::ADDR_ADJUST_SEL:
                    next_state.adjust_sel = wdata_i[7:0];
                ramp_limit_pkg::ADDR_ADJUST_VALUE:
                    next_state.adjust_value = wdata_i;
                ramp_limit_pkg::ADDR_CONTROL:
                begin
                    next_state.terminal_mode    = wdata_i[ramp_limit_pkg::CTRL_TERMINAL_MODE_BIT];
                    next_state.inhibit          = wdata_i[ramp_limit_pkg::CTRL_INHIBIT_BIT];
                    next_state.field_weaken_req = wdata_i[ramp_limit_pkg::CTRL_FIELD_WEAKEN_BIT];
                    // Confirm is a strobe; gain is taken only in the calibration setup
                    if (wdata_i[ramp_limit_pkg::CTRL_CONFIRM_BIT] && state.inhibit &&
                        state.adjust_sel == ramp_limit_pkg::ADJ_MAIN_CHANNEL)
                    begin
                        next_state.gain        = state.adjust_value;
                        next_state.gain_stored = 1'b1;
                    end
                end
                ramp_limit_pkg::ADDR_TERM_ASSIGN:
                    next_state.term_assign = wdata_i[7:0];
                default:
                begin
                end
            endcase
        end

        // Read data stand only in the cycle after the strobe
        next_state.rdata = rd_i ? read_word : 16'h0000;
    end

    // =========================================================
    // Read multiplexer
    always_comb
    begin
        read_word = 16'h0000;
        case (addr_i)
            ramp_limit_pkg::ADDR_PAIR_SELECT:  read_word = {12'h000, state.pair};
            ramp_limit_pkg::ADDR_UPPER_LIMIT:  read_word = state.upper;
            ramp_limit_pkg::ADDR_LOWER_LIMIT:  read_word = state.lower;
            ramp_limit_pkg::ADDR_DRIVE_CONFIG: read_word = {8'h00, state.drive_configuration};
            ramp_limit_pkg::ADDR_COMPENSATION: read_word = state.compensation;
            ramp_limit_pkg::ADDR_ADJUST_SEL:   read_word = {8'h00, state.adjust_sel};
            ramp_limit_pkg::ADDR_ADJUST_VALUE: read_word = state.adjust_value;
            ramp_limit_pkg::ADDR_CONTROL:
            begin
                read_word[ramp_limit_pkg::CTRL_TERMINAL_MODE_BIT] = state.terminal_mode;
                read_word[ramp_limit_pkg::CTRL_INHIBIT_BIT]       = state.inhibit;
                read_word[ramp_limit_pkg::CTRL_FIELD_WEAKEN_BIT]  = state.field_weaken_req;
            end
            ramp_limit_pkg::ADDR_STATUS:
            begin
                read_word[ramp_limit_pkg::STAT_ARMV_FB_BIT]      = armv;
                read_word[ramp_limit_pkg::STAT_TACHO_FB_BIT]     = tacho;
                read_word[ramp_limit_pkg::STAT_FIELD_WEAKEN_BIT] = field_weaken_enable_o;
                read_word[ramp_limit_pkg::STAT_GAIN_STORED_BIT]  = state.gain_stored;
                read_word[ramp_limit_pkg::STAT_CLAMPED_BIT]      = state.clamped;
            end
            ramp_limit_pkg::ADDR_SETPOINT:     read_word = state.setpoint;
            ramp_limit_pkg::ADDR_CHANNEL_GAIN: read_word = state.gain;
            ramp_limit_pkg::ADDR_TERM_ASSIGN:  read_word = {8'h00, state.term_assign};
            default:                           read_word = 16'h0000;
        endcase
    end

    // =========================================================
    // State register
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state                     <= '0;
            state.pair                <= ramp_limit_pkg::PAIR_SELECT_RST;
            state.upper               <= ramp_limit_pkg::UPPER_RST;
            state.lower               <= ramp_limit_pkg::LOWER_RST;
            state.drive_configuration <= ramp_limit_pkg::DRIVE_CONFIG_RST;
            state.adjust_sel          <= ramp_limit_pkg::ADJUST_SEL_RST;
            state.gain                <= ramp_limit_pkg::GAIN_UNITY;
        end
        else
            state <= next_state;
    end

    // =========================================================
    // Outputs
    assign rdata_o                  = state.rdata;
    assign active_pair_o            = state.pair;
    assign use_base_times_o         = (state.pair == 4'h0);
    assign limited_speed_setpoint_o = state.setpoint;
    assign armature_feedback_o      = armv;
    assign tacho_feedback_o         = tacho;
    assign load_drop_compensation_o = armv ? state.compensation : 16'h0000;
    assign field_weaken_enable_o    = state.field_weaken_req && !armv;
    assign main_channel_gain_o      = state.gain;
endmodule
`default_nettype wire

// >>> bench/ramp_limit_properties.sv
`default_nettype none
// ============================================================
// Port-level properties of the ramp pair and limit block
module ramp_limit_checker (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic [3:0]         addr_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    input  wire logic [15:0]        rdata_o,
    input  wire logic               cycle_tick_i,
    input  wire logic [3:0]         active_pair_o,
    input  wire logic               use_base_times_o,
    input  wire logic signed [15:0] limited_speed_setpoint_o,
    input  wire logic               armature_feedback_o,
    input  wire logic               tacho_feedback_o,
    input  wire logic [15:0]        load_drop_compensation_o,
    input  wire logic               field_weaken_enable_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    pair_on_cause_a: assert property ($changed(active_pair_o) |->
        $past(cycle_tick_i) || ($past(wr_i) && $past(addr_i) == 4'h0))
        else $error("pair changed without tick or write");
    pair_readback_a: assert property (rd_i && addr_i == 4'h0 |=>
        rdata_o == {12'h000, $past(active_pair_o)})
        else $error("pair readback differs from pair in effect");
    base_flag_a: assert property (use_base_times_o == (active_pair_o == 4'h0))
        else $error("base time flag disagrees with pair");
    read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside read slot");
    feedback_excl_a: assert property (!(armature_feedback_o && tacho_feedback_o))
        else $error("two feedback sources at once");
    no_weaken_a: assert property (armature_feedback_o |-> !field_weaken_enable_o)
        else $error("field weakening with armature feedback");
    comp_range_a: assert property (armature_feedback_o ? load_drop_compensation_o <= 16'h012C
        : load_drop_compensation_o == 16'h0000)
        else $error("compensation out of range");
    sum_saturate_a: assert property (limited_speed_setpoint_o <= 16'sh0708
        && limited_speed_setpoint_o >= -16'sh0708)
        else $error("setpoint beyond saturation");

    cover property (cycle_tick_i ##1 $changed(active_pair_o));
    cover property (armature_feedback_o && load_drop_compensation_o != 16'h0000);
    cover property (limited_speed_setpoint_o == 16'sh0708);
endmodule
`default_nettype wire

// >>> bench/terminal_panel.sv
`default_nettype none
// ============================================================
// Terminal strip and control-cycle source
module terminal_panel (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] code_i,
    input  wire logic [7:0] mask_i,
    output logic [7:0]      terminal_o,
    output logic            tick_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] count;
    // Unassigned pins toggle so a design reading them is caught
    always @(posedge clk_i or posedge rst_i)
    begin
        int k;
        k = 0;
        if (rst_i)
        begin
            terminal_o <= 8'h00;
            count <= 3'h0;
            tick_o <= 1'b0;
        end
        else
        begin
            for (int t = 0; t < 8; t++)
            begin
                if (mask_i[t] && k < 4)
                begin
                    terminal_o[t] <= code_i[k];
                    k++;
                end
                else
                    terminal_o[t] <= ~terminal_o[t];
            end
            count <= count + 3'h1;
            tick_o <= (count == 3'h7);
        end
    end
endmodule
`default_nettype wire

// >>> bench/ramp_pair_limit_tb.sv
`default_nettype none
module ramp_pair_limit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk_i = 1'b0;
    logic               rst_i = 1'b1;
    logic [3:0]         addr_i = 4'h0;
    logic [15:0]        wdata_i = 16'h0000;
    logic               wr_i = 1'b0;
    logic               rd_i = 1'b0;
    logic [15:0]        rdata_o;
    logic [7:0]         terminal_i;
    logic               cycle_tick_i;
    logic signed [15:0] main_sp = 16'sh0000;
    logic signed [15:0] add_sp = 16'sh0000;
    logic [3:0]         active_pair_o;
    logic               use_base_o;
    logic signed [15:0] setpoint_o;
    logic               arm_o;
    logic               tacho_o;
    logic [15:0]        comp_o;
    logic               weaken_o;
    logic [15:0]        gain_o;
    logic [3:0]         code = 4'h0;
    logic [7:0]         cfg [4] = '{8'h0A, 8'h0B, 8'h28, 8'h29};
    int                 n_fail = 0;
    int                 n_checks = 0;

    ramp_pair_limit DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .terminal_i(terminal_i), .cycle_tick_i(cycle_tick_i),
        .main_setpoint_i(main_sp), .additional_setpoint_i(add_sp), .active_pair_o(active_pair_o),
        .use_base_times_o(use_base_o), .limited_speed_setpoint_o(setpoint_o), .armature_feedback_o(arm_o),
        .tacho_feedback_o(tacho_o), .load_drop_compensation_o(comp_o), .field_weaken_enable_o(weaken_o),
        .main_channel_gain_o(gain_o));
    terminal_panel panel (.clk_i(clk_i), .rst_i(rst_i), .code_i(code), .mask_i(8'hB2),
        .terminal_o(terminal_i), .tick_o(cycle_tick_i));

    initial
    begin
        forever #4 clk_i = ~clk_i;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        check(rdata_o, exp);
    endtask
    task automatic sp(input logic [15:0] m, input logic [15:0] s, input logic [15:0] exp);
        @(posedge clk_i);
        main_sp <= m;
        add_sp <= s;
        repeat (2) @(posedge clk_i);
        #1;
        check(setpoint_o, exp);
    endtask
    task automatic finish_test;
        if (n_fail == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ============================================================
    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h0, 16'h0000);
        rd(4'h1, 16'h0708);
        rd(4'h2, 16'hF8F8);
        rd(4'h3, 16'h000B);
        rd(4'hC, 16'h0000);
        for (int v = 0; v < 16; v++)
        begin
            wr(4'h0, 16'(v));
            rd(4'h0, 16'(v));
            check({12'h000, active_pair_o}, 16'(v));
            check({15'h0, use_base_o}, 16'(v == 0));
        end
        // Terminals 1, 4, 5 and 7 carry code bits 0 to 3
        wr(4'hB, 16'h00B2);
        wr(4'h7, 16'h0001);
        for (int v = 1; v < 16; v++)
        begin
            @(posedge clk_i);
            code <= 4'(v);
            repeat (24) @(posedge clk_i);
            rd(4'h0, 16'(v));
            check({12'h000, active_pair_o}, 16'(v));
        end
        wr(4'h0, 16'h0003);
        check({12'h000, active_pair_o}, 16'h000F);
        wr(4'h7, 16'h0000);
        // Upper kept above lower throughout
        wr(4'h1, 16'h01F4);
        wr(4'h2, 16'hFED4);
        sp(16'h0190, 16'h0032, 16'h01C2);
        sp(16'h0190, 16'h00C8, 16'h01F4);
        rd(4'h9, 16'h01F4);
        rd(4'h8, 16'h0012);
        sp(16'hFF38, 16'hFF38, 16'hFED4);
        wr(4'h1, 16'h04D2);
        rd(4'h1, 16'h04CE);
        wr(4'h2, 16'hFB2E);
        rd(4'h2, 16'hFB32);
        wr(4'h1, 16'h0800);
        wr(4'h2, 16'hF000);
        rd(4'h1, 16'h0708);
        rd(4'h2, 16'hF8F8);
        sp(16'h05DC, 16'h03E8, 16'h0708);
        sp(16'hFA24, 16'hFC18, 16'hF8F8);
        wr(4'h4, 16'h0190);
        rd(4'h4, 16'h012C);
        wr(4'h7, 16'h0004);
        for (int i = 0; i < 4; i++)
        begin
            wr(4'h3, {8'h00, cfg[i]});
            check({14'h0, arm_o, tacho_o}, (i % 2 == 0) ? 16'h0002 : 16'h0001);
            check({15'h0, weaken_o}, (i % 2 == 0) ? 16'h0000 : 16'h0001);
            check(comp_o, (i % 2 == 0) ? 16'h012C : 16'h0000);
        end
        rd(4'hA, 16'h03E8);
        // Confirm counts only while inhibit already stands and selector is 4
        wr(4'h6, 16'h0320);
        wr(4'h5, 16'h0003);
        wr(4'h7, 16'h0002);
        wr(4'h7, 16'h000A);
        wr(4'h5, 16'h0004);
        wr(4'h7, 16'h0000);
        wr(4'h7, 16'h0008);
        rd(4'hA, 16'h03E8);
        wr(4'h7, 16'h0002);
        wr(4'h7, 16'h000A);
        rd(4'hA, 16'h0320);
        check(gain_o, 16'h0320);
        rd(4'h8, 16'h000A);
        rd(4'h9, 16'hF8F8);
        finish_test;
    end

    // Whole sequence needs under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        finish_test;
    end
endmodule

bind ramp_pair_limit ramp_limit_checker u_checker (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cycle_tick_i(cycle_tick_i), .active_pair_o(active_pair_o),
    .use_base_times_o(use_base_times_o), .limited_speed_setpoint_o(limited_speed_setpoint_o),
    .armature_feedback_o(armature_feedback_o), .tacho_feedback_o(tacho_feedback_o),
    .load_drop_compensation_o(load_drop_compensation_o), .field_weaken_enable_o(field_weaken_enable_o));
`default_nettype wire
